/* File: shared/psr_pkg.sv */
package psr_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CTRL    = 16'h4007;
   localparam logic [15:0] IDX_CFG     = 16'h4008;
   localparam logic [15:0] IDX_UV_EN   = 16'h4009;
   localparam logic [15:0] IDX_ON_SRC  = 16'h400E;
   localparam logic [15:0] IDX_OFF_SRC = 16'h400F;
   localparam logic [15:0] IDX_IRQ     = 16'h4012;
   localparam logic [15:0] IDX_MASK    = 16'h401A;

   // Control register fields
   localparam int CTL_CHIP_ON  = 0;
   localparam int CTL_SLEEP    = 1;
   localparam int CTL_SW_RESET = 2;

   // Source record fields
   localparam int STARTUP_FROM_OFF_FLAG_BIT   = 15;
   localparam int ON_RTC_BIT     = 14;
   localparam int ON_GPIO_BIT    = 13;
   localparam int ON_PIN_BIT     = 12;
   localparam int LOW_SUPPLY_WAKE_FLAG_BIT   = 11;
   localparam int ON_WDOG_BIT    = 10;
   localparam int ON_SWREQ_BIT   = 9;
   localparam int RST_CNV_BIT    = 3;
   localparam int RST_SW_BIT     = 2;
   localparam int RST_HW_BIT     = 1;
   localparam int RST_WDOG_BIT   = 0;
   localparam int OFF_INTREG_BIT = 13;
   localparam int OFF_SEQ_BIT    = 12;
   localparam int OFF_GPIO_BIT   = 11;
   localparam int OFF_SUPPLY_BIT = 10;
   localparam int OFF_THERM_BIT  = 9;
   localparam int OFF_SWREQ_BIT  = 6;
   localparam int OFF_PIN_BIT    = 4;

   // Interrupt flag fields
   localparam int IRQ_ON_WAKE   = 0;
   localparam int IRQ_SLEEP_OFF = 1;
   localparam int IRQ_POR       = 2;

   // Values after reset
   localparam logic [REG_W-1:0] MASK_RST = 16'h0007;
   localparam logic [REG_W-1:0] IRQ_RST  = 16'h0000;
   localparam logic [REG_W-1:0] SRC_RST  = 16'h0000;
   localparam logic [8:0]       CFG_RST  = 9'h000;
   localparam logic [14:0]      UVEN_RST = 15'h0000;

   // Action encodings
   localparam logic [1:0] PIN_ACT_ON  = 2'h1;
   localparam logic [1:0] PIN_ACT_OFF = 2'h2;
   localparam logic [1:0] WDOG_WAKE   = 2'h1;
   localparam logic [1:0] WDOG_RESET  = 2'h2;

   typedef enum logic [1:0] {PS_OFF, PS_ON, PS_SLEEP, PS_REBOOT} psr_state_t;

   typedef struct packed {
      logic       syslo_off;
      logic [1:0] wdog_mode;
      logic [1:0] pin_act;
      logic       gpio_wake_en;
      logic       gpio_sleep_en;
      logic       gpio_off_en;
      logic       gpio_on_en;
   } psr_cfg_t;

   typedef struct packed {
      logic        rtc_alarm;
      logic        gpio_on;
      logic        gpio_off;
      logic        gpio_sleep;
      logic        gpio_wake;
      logic        on_pin;
      logic        wdog_timeout;
      logic        supply_low;
      logic        supply_shutdown;
      logic        thermal_shutdown;
      logic        seq_fail;
      logic        intreg_err;
      logic        hw_reset;
      logic        supply_good;
      logic [14:0] cnv_uv;
   } psr_pin_t;

   localparam int PIN_W = $bits(psr_pin_t);
endpackage

/* File: rtl/psr_evsync.sv */
module psr_evsync
   import psr_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and control
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         ce_in,
   // Asynchronous levels
   input  wire logic [W-1:0] d_in,
   // Synchronised level and rising-edge pulse
   output logic      [W-1:0] lvl_out,
   output logic      [W-1:0] rise_out
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
               prev_reg[i] <= 1'b0;
            end else if (ce_in) begin
               meta_reg[i] <= d_in[i];
               sync_reg[i] <= meta_reg[i];
               prev_reg[i] <= sync_reg[i];
            end
         end
         assign lvl_out[i]  = sync_reg[i];
         assign rise_out[i] = sync_reg[i] & ~prev_reg[i];
      end
   endgenerate
endmodule

/* File: rtl/psr_recorder.sv */
module psr_recorder
   import psr_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              CLOCK_IN,
   input  wire logic              RSTN_IN,
   input  wire logic              CE_IN,
   // APB slave
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [ADDR_W-1:0] PADDR_IN,
   input  wire logic [DATA_W-1:0] PWDATA_IN,
   output logic      [DATA_W-1:0] PRDATA_OUT,
   output logic                   PREADY_OUT,
   output logic                   PSLVERR_OUT,
   // Event sources, asynchronous levels
   input  wire psr_pin_t          EVENTS_IN,
   // Power state and primary interrupt
   output psr_state_t             POWER_STATE_OUT,
   output logic                   IRQ_OUT
);
   logic       rst_meta_reg;
   logic       rst_n;
   logic [PIN_W-1:0] lvl_vec;
   logic [PIN_W-1:0] rise_vec;
   psr_pin_t   lv;
   psr_pin_t   ev;

   psr_state_t       state_reg, state_next;
   psr_cfg_t         cfg_reg;
   logic [14:0]      uv_en_reg;
   logic [REG_W-1:0] on_src_reg, on_src_next;
   logic [REG_W-1:0] off_src_reg, off_src_next;
   logic [REG_W-1:0] irq_reg, irq_next;
   logic [REG_W-1:0] mask_reg;
   logic             por_done_reg;
   logic             irq_out_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic             rd_valid_reg;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   psr_evsync #(.W(PIN_W)) u_sync (
      .clk_in   (CLOCK_IN),
      .rst_n_in (rst_n),
      .ce_in    (CE_IN),
      .d_in     (EVENTS_IN),
      .lvl_out  (lvl_vec),
      .rise_out (rise_vec)
   );
   assign lv = psr_pin_t'(lvl_vec);
   assign ev = psr_pin_t'(rise_vec);

   // Bus decode
   wire [15:0] idx      = PADDR_IN[ADDR_W-1:2];
   wire hit_ctrl        = (idx == IDX_CTRL);
   wire hit_cfg         = (idx == IDX_CFG);
   wire hit_uven        = (idx == IDX_UV_EN);
   wire hit_on          = (idx == IDX_ON_SRC);
   wire hit_off         = (idx == IDX_OFF_SRC);
   wire hit_irq         = (idx == IDX_IRQ);
   wire hit_mask        = (idx == IDX_MASK);
   wire hit_any         = (PADDR_IN[1:0] == 2'h0) &
                          (hit_ctrl | hit_cfg | hit_uven | hit_on | hit_off | hit_irq | hit_mask);
   wire access          = PSEL_IN & PENABLE_IN & CE_IN;
   wire wr              = access & PWRITE_IN & hit_any;
   wire [REG_W-1:0] wd  = PWDATA_IN[REG_W-1:0];

   // Power state decode
   wire st_off   = (state_reg == PS_OFF);
   wire st_on    = (state_reg == PS_ON);
   wire st_sleep = (state_reg == PS_SLEEP);
   wire st_live  = st_on | st_sleep;

   // Software requests through the control register
   wire wr_ctrl  = wr & hit_ctrl;
   wire sw_off   = wr_ctrl & ~wd[CTL_CHIP_ON] & st_live;
   wire sw_sleep = wr_ctrl & wd[CTL_SLEEP] & st_on;
   wire sw_wake  = wr_ctrl & ~wd[CTL_SLEEP] & st_sleep;
   wire sw_rst   = wr_ctrl & wd[CTL_SW_RESET] & st_live;

   // Configured request decode
   wire pin_on_hit    = ev.on_pin & (cfg_reg.pin_act == PIN_ACT_ON);
   wire pin_off_hit   = ev.on_pin & (cfg_reg.pin_act == PIN_ACT_OFF);
   wire gpio_on_hit   = ev.gpio_on & cfg_reg.gpio_on_en;
   wire gpio_off_hit  = ev.gpio_off & cfg_reg.gpio_off_en;
   wire gpio_slp_hit  = ev.gpio_sleep & cfg_reg.gpio_sleep_en;
   wire gpio_wake_hit = ev.gpio_wake & cfg_reg.gpio_wake_en;
   wire wdog_wake_hit = ev.wdog_timeout & (cfg_reg.wdog_mode == WDOG_WAKE);
   wire wdog_rst_hit  = ev.wdog_timeout & (cfg_reg.wdog_mode == WDOG_RESET);
   wire syslo_off_hit = ev.supply_low & cfg_reg.syslo_off;
   wire syslo_wk_hit  = ev.supply_low & ~cfg_reg.syslo_off;
   wire cnv_uv_hit    = |(ev.cnv_uv & uv_en_reg);

   // Cause vectors for the off, reboot, wake and on transitions; sleep has none
   logic [REG_W-1:0] off_c, rb_c, wake_c, on_c;
   always_comb begin
      off_c = '0;
      off_c[OFF_SWREQ_BIT]  = sw_off;
      off_c[OFF_PIN_BIT]    = pin_off_hit;
      off_c[OFF_THERM_BIT]  = ev.thermal_shutdown;
      off_c[OFF_SUPPLY_BIT] = ev.supply_shutdown | syslo_off_hit;
      off_c[OFF_GPIO_BIT]   = gpio_off_hit;
      off_c[OFF_SEQ_BIT]    = ev.seq_fail;
      off_c[OFF_INTREG_BIT] = ev.intreg_err;
      if (!st_live) off_c = '0;
      rb_c = '0;
      rb_c[RST_WDOG_BIT] = wdog_rst_hit;
      rb_c[RST_HW_BIT]   = ev.hw_reset;
      rb_c[RST_SW_BIT]   = sw_rst;
      rb_c[RST_CNV_BIT]  = cnv_uv_hit;
      if (!st_live) rb_c = '0;
      wake_c = '0;
      wake_c[ON_SWREQ_BIT] = sw_wake;
      wake_c[ON_WDOG_BIT]  = wdog_wake_hit;
      wake_c[ON_RTC_BIT]   = ev.rtc_alarm;
      wake_c[ON_GPIO_BIT]  = gpio_wake_hit | gpio_on_hit;
      wake_c[LOW_SUPPLY_WAKE_FLAG_BIT] = syslo_wk_hit;
      wake_c[ON_PIN_BIT]   = pin_on_hit;
      if (!st_sleep) wake_c = '0;
      on_c = '0;
      on_c[ON_RTC_BIT]  = ev.rtc_alarm;
      on_c[ON_GPIO_BIT] = gpio_on_hit;
      on_c[ON_PIN_BIT]  = pin_on_hit;
      on_c[STARTUP_FROM_OFF_FLAG_BIT] = |on_c;
      if (!(st_off && lv.supply_good)) on_c = '0;
   end

   // Priority: shutdown, then reboot, then wake, then sleep
   wire take_off   = |off_c;
   wire take_rb    = ~take_off & (|rb_c);
   wire take_wake  = ~take_off & ~take_rb & (|wake_c);
   wire take_on    = |on_c;
   wire take_sleep = ~take_off & ~take_rb & st_on & (sw_sleep | gpio_slp_hit);
   wire rb_done    = (state_reg == PS_REBOOT) & lv.supply_good;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PS_OFF:    if (take_on) state_next = PS_ON;
         PS_ON: begin
            if (take_off) state_next = PS_OFF;
            else if (take_rb) state_next = PS_REBOOT;
            else if (take_sleep) state_next = PS_SLEEP;
         end
         PS_SLEEP: begin
            if (take_off) state_next = PS_OFF;
            else if (take_rb) state_next = PS_REBOOT;
            else if (take_wake) state_next = PS_ON;
         end
         PS_REBOOT: if (rb_done) state_next = PS_ON;
      endcase
   end

   // Records hold only the latest event of their kind
   assign on_src_next  = take_on ? on_c :
                         take_wake ? wake_c :
                         take_rb ? rb_c : on_src_reg;
   assign off_src_next = take_off ? off_c : off_src_reg;

   // Hardware set beats a simultaneous software clear
   wire entering_on  = (state_next == PS_ON) & ~st_on;
   wire entering_low = (state_next != PS_ON) & st_on |
                       (state_next == PS_OFF) & ~st_off |
                       (state_next == PS_REBOOT) & (state_reg != PS_REBOOT);
   wire [REG_W-1:0] irq_set = {13'h0000, ~por_done_reg, entering_low, entering_on};
   wire [REG_W-1:0] irq_clr = (wr & hit_irq) ? wd : '0;
   assign irq_next = (irq_reg & ~irq_clr) | irq_set;

   wire [REG_W-1:0] unmasked = irq_reg & ~mask_reg;

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= PS_OFF;
         on_src_reg   <= SRC_RST;
         off_src_reg  <= SRC_RST;
         irq_reg      <= IRQ_RST;
         por_done_reg <= 1'b0;
         irq_out_reg  <= 1'b0;
      end else if (CE_IN) begin
         state_reg    <= state_next;
         on_src_reg   <= on_src_next;
         off_src_reg  <= off_src_next;
         irq_reg      <= irq_next;
         por_done_reg <= 1'b1;
         irq_out_reg  <= |unmasked;
      end
   end

   // Software-owned configuration
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg   <= psr_cfg_t'(CFG_RST);
         uv_en_reg <= UVEN_RST;
         mask_reg  <= MASK_RST;
      end else begin
         if (wr & hit_cfg) cfg_reg <= psr_cfg_t'(wd[8:0]);
         if (wr & hit_uven) uv_en_reg <= wd[14:0];
         if (wr & hit_mask) mask_reg <= {13'h0000, wd[2:0]};
      end
   end

   // Read data leaves a flop; a setup cycle that fell while frozen
   // is captured late, and ready is held back until it is
   wire [REG_W-1:0] ctrl_view = {13'h0000, 1'b0, st_sleep, ~st_off};
   wire [REG_W-1:0] rd_mux =
      hit_ctrl ? ctrl_view :
      hit_cfg  ? {7'h00, cfg_reg} :
      hit_uven ? {1'b0, uv_en_reg} :
      hit_on   ? on_src_reg :
      hit_off  ? off_src_reg :
      hit_irq  ? irq_reg :
      hit_mask ? mask_reg : '0;

   wire rd_capture = CE_IN & PSEL_IN & ~PWRITE_IN & ~rd_valid_reg;
   wire bus_done   = PSEL_IN & PENABLE_IN & PREADY_OUT;

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) rdata_reg <= '0;
      else if (rd_capture) rdata_reg <= {16'h0000, hit_any ? rd_mux : 16'h0000};
   end

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) rd_valid_reg <= 1'b0;
      else if (CE_IN) rd_valid_reg <= ~bus_done & (rd_valid_reg | rd_capture);
   end

   assign PRDATA_OUT      = rdata_reg;
   assign PREADY_OUT      = CE_IN & (PWRITE_IN | rd_valid_reg);
   assign PSLVERR_OUT     = PSEL_IN & PENABLE_IN & ~hit_any;
   assign POWER_STATE_OUT = state_reg;
   assign IRQ_OUT         = irq_out_reg;

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!rst_n);

   alarm_from_off_a: assert property (CE_IN && st_off && ev.rtc_alarm && lv.supply_good
      |=> state_reg == PS_ON && on_src_reg[STARTUP_FROM_OFF_FLAG_BIT] && on_src_reg[ON_RTC_BIT])
      else $error("alarm in off did not start on");
   alarm_wake_a: assert property (CE_IN && st_sleep && ev.rtc_alarm && !take_off && !take_rb
      |=> state_reg == PS_ON && on_src_reg[ON_RTC_BIT] && !on_src_reg[STARTUP_FROM_OFF_FLAG_BIT])
      else $error("alarm in sleep did not wake");
   gpio_gate_a: assert property (CE_IN && take_on
      |=> on_src_reg[ON_GPIO_BIT] == $past(gpio_on_hit))
      else $error("gpio on flag wrong");
   sw_wake_a: assert property (CE_IN && sw_wake && !take_off && !take_rb
      |=> state_reg == PS_ON && on_src_reg[ON_SWREQ_BIT])
      else $error("software wake missing");
   sleep_no_off_a: assert property (CE_IN && take_sleep
      |=> state_reg == PS_SLEEP && off_src_reg == $past(off_src_reg))
      else $error("sleep touched off record");
   supply_gate_a: assert property (CE_IN && st_off && !lv.supply_good
      |=> state_reg == PS_OFF)
      else $error("on without supply good");
   reboot_seq_a: assert property (CE_IN && take_rb ##1 CE_IN && lv.supply_good
      |=> state_reg == PS_ON && (on_src_reg[3:0] != 4'h0))
      else $error("reboot not off then on");
   sw_off_a: assert property (CE_IN && sw_off
      |=> state_reg == PS_OFF && off_src_reg[OFF_SWREQ_BIT])
      else $error("software off missing");
   w1c_hold_a: assert property (CE_IN && irq_reg[IRQ_ON_WAKE] && !irq_clr[IRQ_ON_WAKE]
      |=> irq_reg[IRQ_ON_WAKE])
      else $error("flag lost without clear");
   set_wins_a: assert property (CE_IN && entering_on && irq_clr[IRQ_ON_WAKE]
      |=> irq_reg[IRQ_ON_WAKE])
      else $error("set lost to clear");
   irq_level_a: assert property (CE_IN && |unmasked ##1 CE_IN && |unmasked
      |-> IRQ_OUT)
      else $error("primary irq not raised");
   mask_reset_a: assert property ($rose(rst_n) |-> mask_reg == MASK_RST && !IRQ_OUT)
      else $error("mask reset value wrong");
   pin_on_a: assert property (CE_IN && st_off && pin_on_hit && lv.supply_good
      |=> st_on && on_src_reg[ON_PIN_BIT] && on_src_reg[STARTUP_FROM_OFF_FLAG_BIT])
      else $error("pin on request lost");
   pin_off_a: assert property (CE_IN && st_live && pin_off_hit
      |=> st_off && off_src_reg[OFF_PIN_BIT])
      else $error("pin off request lost");
   gpio_off_a: assert property (CE_IN && st_live && gpio_off_hit
      |=> st_off && off_src_reg[OFF_GPIO_BIT])
      else $error("gpio off request lost");
   wdog_wake_a: assert property (CE_IN && take_wake && wdog_wake_hit
      |=> st_on && on_src_reg[ON_WDOG_BIT])
      else $error("watchdog wake missing");
   syslo_off_a: assert property (CE_IN && st_live && syslo_off_hit
      |=> st_off && off_src_reg[OFF_SUPPLY_BIT])
      else $error("low supply off missing");
   shutdown_a: assert property (CE_IN && st_live && ev.supply_shutdown
      |=> st_off && off_src_reg[OFF_SUPPLY_BIT])
      else $error("supply shutdown missing");
   uv_gate_a: assert property (CE_IN && take_rb
      |=> on_src_reg[RST_CNV_BIT] == $past(cnv_uv_hit))
      else $error("converter reboot not gated");
   thermal_a: assert property (CE_IN && st_live && ev.thermal_shutdown
      |=> st_off && off_src_reg[OFF_THERM_BIT])
      else $error("thermal off missing");
   seq_fail_a: assert property (CE_IN && st_live && ev.seq_fail
      |=> st_off && off_src_reg[OFF_SEQ_BIT])
      else $error("sequence failure off missing");
   intreg_a: assert property (CE_IN && st_live && ev.intreg_err
      |=> st_off && off_src_reg[OFF_INTREG_BIT])
      else $error("regulator error off missing");
   sw_sleep_a: assert property (CE_IN && sw_sleep && !take_off && !take_rb
      |=> st_sleep)
      else $error("software sleep missing");
   reboot_hold_a: assert property (CE_IN && state_reg == PS_REBOOT && !lv.supply_good
      |=> state_reg == PS_REBOOT)
      else $error("reboot ended without supply");
   por_flag_a: assert property (CE_IN && $rose(rst_n) |=> irq_reg[IRQ_POR])
      else $error("power on flag missing");
   off_flag_a: assert property (CE_IN && take_off
      |=> irq_reg[IRQ_SLEEP_OFF])
      else $error("off flag missing");
   on_flag_a: assert property (CE_IN && take_on |=> irq_reg[IRQ_ON_WAKE])
      else $error("on flag missing");
   w1c_clear_a: assert property (CE_IN && irq_clr[IRQ_POR] && !irq_set[IRQ_POR]
      |=> !irq_reg[IRQ_POR])
      else $error("flag not cleared");
   mask_gate_a: assert property (CE_IN && !(|unmasked) |=> !IRQ_OUT)
      else $error("masked flag raised irq");
   off_record_a: assert property (CE_IN && take_off |=> off_src_reg == $past(off_c))
      else $error("off record not replaced");
   wake_record_a: assert property (CE_IN && take_wake |=> on_src_reg == $past(wake_c))
      else $error("wake record not replaced");

   on_cov: cover property (st_off ##1 st_on);
   sleep_cov: cover property (st_on ##1 st_sleep ##[1:50] st_on);
   reboot_cov: cover property (state_reg == PS_REBOOT ##1 st_on);
   irq_cov: cover property (IRQ_OUT ##[1:20] !IRQ_OUT);
   ready_wait_cov: cover property (PSEL_IN && PENABLE_IN && !PREADY_OUT ##1 PREADY_OUT);
endmodule

/* File: tb/psr_event_src.sv */
module psr_event_src
   import psr_pkg::*;
(
   // Clock and request
   input  wire logic       clk_in,
   input  wire logic       fire_in,
   input  wire logic [4:0] sel_in,
   input  wire logic       good_in,
   // Event levels
   output psr_pin_t        events_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [PIN_W-1:0] lvl_reg  = '0;
   logic [2:0]       hold_reg = 3'h0;
   // A source holds its cause a few cycles, then drops it
   always_ff @(posedge clk_in) begin
      if (fire_in) begin
         lvl_reg  <= PIN_W'(1) << sel_in;
         hold_reg <= 3'h4;
      end else if (hold_reg != 3'h0) begin
         hold_reg <= hold_reg - 3'h1;
      end else begin
         lvl_reg <= '0;
      end
   end
   // Supply-good is a level, never a pulse
   assign events_out = psr_pin_t'({lvl_reg[PIN_W-1:16], good_in, lvl_reg[14:0]});
endmodule

/* File: tb/test_psr_recorder.sv */
module test_psr_recorder;
   import psr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLOCK_IN = 1'b0;
   logic RSTN_IN = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] PRDATA_OUT;
   logic PREADY_OUT;
   logic PSLVERR_OUT;
   psr_pin_t events;
   psr_state_t POWER_STATE_OUT;
   logic IRQ_OUT;
   logic fire_r = 1'b0;
   logic [4:0] sel = 5'h00;
   logic good = 1'b1;
   logic ce = 1'b1;
   logic [31:0] rdat;
   logic rerr;
   int n_errors = 0;
   int total_checks = 0;
   int k;
   int offs[4] = '{19, 20, 18, 17};
   logic [15:0] offe[4] = '{16'h0200, 16'h0400, 16'h1000, 16'h2000};

   always #12.5 CLOCK_IN = ~CLOCK_IN;

   psr_recorder u_dut (.CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .CE_IN(ce),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
      .PSLVERR_OUT(PSLVERR_OUT), .EVENTS_IN(events),
      .POWER_STATE_OUT(POWER_STATE_OUT), .IRQ_OUT(IRQ_OUT));

   psr_event_src u_src (.clk_in(CLOCK_IN), .fire_in(fire_r), .sel_in(sel),
      .good_in(good), .events_out(events));

   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // Master holds the request until pready is sampled high
   task apb(input logic w, input logic [15:0] i, input logic [31:0] d);
      @(posedge CLOCK_IN);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge CLOCK_IN);
      penable <= 1'b1;
      do begin
         @(posedge CLOCK_IN);
      end while (PREADY_OUT !== 1'b1);
      rdat = PRDATA_OUT;
      rerr = PSLVERR_OUT;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [15:0] i, input logic [15:0] d);
      apb(1'b1, i, {16'h0000, d});
   endtask

   task fire(input int s);
      if (s >= 0) begin
         @(posedge CLOCK_IN);
         sel <= s[4:0];
         fire_r <= 1'b1;
         @(posedge CLOCK_IN);
         fire_r <= 1'b0;
      end
      repeat (12) @(posedge CLOCK_IN);
   endtask

   // Negative source index: no event is fired; any transition came from a register write
   task step(input int s, input psr_state_t st, input logic [15:0] i,
             input logic [15:0] m, input logic [15:0] e);
      fire(s);
      chk(32'(POWER_STATE_OUT), 32'(st));
      apb(1'b0, i, 32'h0);
      chk({16'h0000, rdat[15:0] & m}, {16'h0000, e});
   endtask

   function automatic logic [15:0] one_hot(input int b);
      one_hot = 16'h0001 << b;
   endfunction

   task done(input string s);
      $display("test %s finished", s);
   endtask

   initial begin
      #(25 * 30000);
      n_errors++;
      complete_run;
   end

   initial begin
      void'($urandom(32'h33EF));
      repeat (16) @(posedge CLOCK_IN);
      RSTN_IN <= 1'b1;
      repeat (3) @(posedge CLOCK_IN);
      step(-1, PS_OFF, IDX_MASK, 16'hFFFF, MASK_RST);
      step(-1, PS_OFF, IDX_IRQ, 16'hFFFF, 16'h0004);
      chk(32'(IRQ_OUT), 32'h0);
      apb(1'b0, 16'h4000, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      wr(IDX_IRQ, 16'h0000);
      step(-1, PS_OFF, IDX_IRQ, 16'hFFFF, 16'h0004);
      wr(IDX_IRQ, 16'h0004);
      step(-1, PS_OFF, IDX_IRQ, 16'hFFFF, 16'h0000);
      done("reset_and_clear");
      good <= 1'b0;
      step(28, PS_OFF, IDX_ON_SRC, 16'hFFFF, 16'h0000);
      good <= 1'b1;
      step(28, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'hC000);
      step(-1, PS_ON, IDX_IRQ, 16'h0001, 16'h0001);
      wr(IDX_MASK, 16'h0006);
      repeat (3) @(posedge CLOCK_IN);
      chk(32'(IRQ_OUT), 32'h1);
      wr(IDX_IRQ, 16'h0001);
      repeat (3) @(posedge CLOCK_IN);
      chk(32'(IRQ_OUT), 32'h0);
      wr(IDX_MASK, 16'h0007);
      done("alarm_and_irq");
      wr(IDX_CTRL, 16'h0003);
      step(-1, PS_SLEEP, IDX_OFF_SRC, 16'hFFFF, 16'h0000);
      step(-1, PS_SLEEP, IDX_IRQ, 16'h0002, 16'h0002);
      step(28, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'h4000);
      wr(IDX_CTRL, 16'h0003);
      wr(IDX_CTRL, 16'h0001);
      step(-1, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'h0200);
      wr(IDX_CTRL, 16'h0000);
      step(-1, PS_OFF, IDX_OFF_SRC, 16'hFFFF, 16'h0040);
      for (int j = 0; j < 4; j++) begin
         step(28, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'hC000);
         step(offs[j], PS_OFF, IDX_OFF_SRC, 16'hFFFF, offe[j]);
      end
      done("software_and_faults");
      wr(IDX_CFG, 16'h0000);
      step(27, PS_OFF, IDX_ON_SRC, 16'hFFFF, 16'hC000);
      wr(IDX_CFG, 16'h000F);
      step(27, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'hA000);
      step(26, PS_OFF, IDX_OFF_SRC, 16'hFFFF, 16'h0800);
      step(28, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'hC000);
      step(25, PS_SLEEP, IDX_OFF_SRC, 16'hFFFF, 16'h0800);
      step(24, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'h2000);
      wr(IDX_CFG, 16'h0020);
      step(23, PS_OFF, IDX_OFF_SRC, 16'hFFFF, 16'h0010);
      wr(IDX_CFG, 16'h0010);
      step(23, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'h9000);
      wr(IDX_CTRL, 16'h0003);
      step(23, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'h1000);
      done("gpio_and_pin");
      wr(IDX_CFG, 16'h0040);
      wr(IDX_CTRL, 16'h0003);
      step(22, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'h0400);
      wr(IDX_CFG, 16'h0000);
      wr(IDX_CTRL, 16'h0003);
      step(21, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'h0800);
      wr(IDX_CFG, 16'h0100);
      step(21, PS_OFF, IDX_OFF_SRC, 16'hFFFF, 16'h0400);
      step(28, PS_ON, IDX_ON_SRC, 16'hFFFF, 16'hC000);
      done("watchdog_and_supply");
      wr(IDX_CFG, 16'h0080);
      step(22, PS_ON, IDX_ON_SRC, 16'h000F, 16'h0001);
      step(16, PS_ON, IDX_ON_SRC, 16'h000F, 16'h0002);
      wr(IDX_CTRL, 16'h0005);
      step(-1, PS_ON, IDX_ON_SRC, 16'h000F, 16'h0004);
      k = $urandom_range(14, 0);
      wr(IDX_UV_EN, one_hot(k));
      step((k + 1) % 15, PS_ON, IDX_ON_SRC, 16'h000F, 16'h0004);
      step(k, PS_ON, IDX_ON_SRC, 16'h000F, 16'h0008);
      done("reboots");
      // Frozen cycles lose a short event and stall the bus until enabled
      ce <= 1'b0;
      fire(19);
      chk(32'(POWER_STATE_OUT), 32'(PS_ON));
      fork
         apb(1'b0, IDX_MASK, 32'h0);
         begin
            repeat (4) @(posedge CLOCK_IN);
            ce <= 1'b1;
         end
      join
      chk(rdat, {16'h0000, MASK_RST});
      fire(-1);
      chk(32'(POWER_STATE_OUT), 32'(PS_ON));
      done("clock_enable");
      complete_run;
   end
endmodule
